// File: design/pwm_decode_pkg.sv
/*
 Package for the half-bridge PWM input decoder: mode codes, the mode pin
 strap encoding, the per-phase gate command struct and reset values.
 Assumes a single 50 MHz system clock and three phases.
*/
package pwm_decode_pkg;

  // Number of half-bridges
  localparam int PHASE_COUNT = 3;

  // Mode field encodings
  localparam logic [1:0] MODE_SIX_INPUT = 2'h0;
  localparam logic [1:0] MODE_THREE_INPUT = 2'h1;

  // Mode pin strap levels as seen by the pin sensing front end
  localparam logic [1:0] STRAP_GROUND = 2'h0; // Tied to analog_ground
  localparam logic [1:0] STRAP_RES_47K = 2'h1; // 47 kOhm to analog_ground

  // Reset values
  localparam logic RESET_GATE = 1'b0;
  localparam logic [1:0] RESET_SYNC = 2'h0;
  localparam logic [2:0] RESET_PIN_SYNC = 3'h0; // Three-flop pin stages
  localparam logic RESET_LEVEL = 1'h0; // Settled levels and flags

  // Gate command pair for one half-bridge
  typedef struct packed {
    logic high_gate_cmd;
    logic low_gate_cmd;
  } gate_pair_s;

  // Inputs of one phase
  typedef struct packed {
    logic phase_high_input;
    logic phase_low_input;
  } phase_in_s;

  // Switch node state of one phase
  typedef enum logic [2:0] {
    NODE_HIZ  = 3'b001,
    NODE_LOW  = 3'b010,
    NODE_HIGH = 3'b100
  } switch_node_state_e;

endpackage : pwm_decode_pkg

// File: design/halfbridge_pwm_input_decoder.sv
/*
 Half-bridge PWM input decoder for three phases, six-input and
 three-input modes. Phase inputs and mode strap come from pins and are
 synchronised with three flops; a change counts when flops two and three
 agree. Outputs are registered gate commands and switch node states.
 Assumes the controller idles all inputs low around any mode change.
*/
`timescale 1ns/1ps

module halfbridge_pwm_input_decoder
  import pwm_decode_pkg::*;
#(
  parameter int PHASES = PHASE_COUNT // Half-bridge count
) (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic hw_config, // 1: mode from strap, 0: from mode field
  input wire logic [1:0] pwm_mode_field, // Configured mode code
  input wire logic [1:0] mode_strap, // Sensed mode pin level code
  input wire phase_in_s [PHASES-1:0] phase_in, // Per-phase inputs
  output gate_pair_s [PHASES-1:0] gate_cmd, // Per-phase gate commands
  output switch_node_state_e [PHASES-1:0] switch_node_state, // Node
  output logic mode_unsupported // Selected mode not decoded here
);

  // Elaboration checks: the logic needs a phase and distinct codes
  if (PHASES < 1) begin : g_bad_phases
    $error("PHASES must be at least one");
  end
  if (MODE_SIX_INPUT == MODE_THREE_INPUT) begin : g_bad_modes
    $error("Six-input and three-input mode codes must differ");
  end
  if (STRAP_GROUND == STRAP_RES_47K) begin : g_bad_straps
    $error("Mode strap codes must differ");
  end

  // Mode source synchroniser stages and their settled levels
  logic [2:0] hw_sync_reg;
  logic [1:0] field_s1_reg;
  logic [1:0] field_s2_reg;
  logic [1:0] field_s3_reg;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  logic [1:0] strap_s3_reg;
  logic hw_cfg_reg;
  logic [1:0] field_reg;
  logic [1:0] strap_reg;

  // Source select pin: three-flop shift, only stage one sees the pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_sync_reg <= RESET_PIN_SYNC;
    end else begin
      hw_sync_reg <= {hw_sync_reg[1:0], hw_config};
    end
  end

  // Mode field stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      field_s1_reg <= RESET_SYNC;
      field_s2_reg <= RESET_SYNC;
      field_s3_reg <= RESET_SYNC;
    end else begin
      field_s1_reg <= pwm_mode_field;
      field_s2_reg <= field_s1_reg;
      field_s3_reg <= field_s2_reg;
    end
  end

  // Mode strap stages; the strap is a pin and may move at any time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg <= RESET_SYNC;
      strap_s2_reg <= RESET_SYNC;
      strap_s3_reg <= RESET_SYNC;
    end else begin
      strap_s1_reg <= mode_strap;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
    end
  end

  // A level counts only once stages two and three agree, so a short
  // glitch on a pin never reaches the mode decode
  wire hw_stable = hw_sync_reg[1] == hw_sync_reg[2];
  wire field_stable = field_s2_reg == field_s3_reg;
  wire strap_stable = strap_s2_reg == strap_s3_reg;

  // Settled source select: 1 takes the strap, 0 the mode field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_cfg_reg <= RESET_LEVEL;
    end else if (hw_stable) begin
      hw_cfg_reg <= hw_sync_reg[2];
    end
  end

  // Settled mode field; resets to six-input so the gates start off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      field_reg <= MODE_SIX_INPUT;
    end else if (field_stable) begin
      field_reg <= field_s3_reg;
    end
  end

  // Settled mode strap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= STRAP_GROUND;
    end else if (strap_stable) begin
      strap_reg <= strap_s3_reg;
    end
  end

  // Strap decode: tied to ground is six-input, 47 kOhm is three-input
  wire strap_six = strap_reg == STRAP_GROUND;
  wire strap_three = strap_reg == STRAP_RES_47K;

  // Field decode: 00 six-input, 01 three-input, the rest not served here
  wire field_six = field_reg == MODE_SIX_INPUT;
  wire field_three = field_reg == MODE_THREE_INPUT;

  // Source selection; at most one of the two modes is ever true
  wire six_mode = hw_cfg_reg ? strap_six : field_six;
  wire three_mode = hw_cfg_reg ? strap_three : field_three;
  wire any_mode = six_mode || three_mode;
  wire mode_unsupported_next = !any_mode;

  // Per-phase decode; an unserved mode turns every gate of the phase off
  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      // Pin synchroniser stages and settled input levels
      logic [2:0] hi_sync_reg;
      logic [2:0] lo_sync_reg;
      logic hi_reg;
      logic lo_reg;
      // Registered outputs of this phase
      gate_pair_s gate_reg;
      switch_node_state_e node_reg;

      // Stage agreement, as for the mode sources
      wire hi_stable = hi_sync_reg[1] == hi_sync_reg[2];
      wire lo_stable = lo_sync_reg[1] == lo_sync_reg[2];

      // Six-input: exactly one input set drives its own gate; both set
      // or both clear leave the node floating
      wire six_hi = hi_reg && !lo_reg;
      wire six_lo = lo_reg && !hi_reg;

      // Three-input: a clear low input floats the node; with it set the
      // high input picks which gate conducts
      wire three_float = !lo_reg;
      wire three_hi = !three_float && hi_reg;
      wire three_lo = !three_float && !hi_reg;

      // Gate selection; the two gates of a pair are never on together
      wire hi_next = six_mode ? six_hi : (three_mode && three_hi);
      wire lo_next = six_mode ? six_lo : (three_mode && three_lo);
      wire gate_pair_s gate_next = {hi_next, lo_next};

      // Node state follows the gate that conducts, floating if none does
      wire switch_node_state_e node_next =
        hi_next ? NODE_HIGH : (lo_next ? NODE_LOW : NODE_HIZ);

      // High input stages: only stage one sees the pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hi_sync_reg <= RESET_PIN_SYNC;
        end else begin
          hi_sync_reg <= {hi_sync_reg[1:0], phase_in[p].phase_high_input};
        end
      end

      // Low input stages: only stage one sees the pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          lo_sync_reg <= RESET_PIN_SYNC;
        end else begin
          lo_sync_reg <= {lo_sync_reg[1:0], phase_in[p].phase_low_input};
        end
      end

      // Settled high input level
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          hi_reg <= RESET_LEVEL;
        end else if (hi_stable) begin
          hi_reg <= hi_sync_reg[2];
        end
      end

      // Settled low input level
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          lo_reg <= RESET_LEVEL;
        end else if (lo_stable) begin
          lo_reg <= lo_sync_reg[2];
        end
      end

      // Registered gate commands; both gates off while reset is held
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          gate_reg <= '{RESET_GATE, RESET_GATE};
        end else begin
          gate_reg <= gate_next;
        end
      end

      // Registered node state; floating while reset is held
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          node_reg <= NODE_HIZ;
        end else begin
          node_reg <= node_next;
        end
      end

      // Outputs come straight from this phase's flops
      assign gate_cmd[p] = gate_reg;
      assign switch_node_state[p] = node_reg;
    end
  endgenerate

  // Unserved mode flag, registered in step with the gates it explains
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_unsupported <= RESET_LEVEL;
    end else begin
      mode_unsupported <= mode_unsupported_next;
    end
  end

endmodule : halfbridge_pwm_input_decoder

// File: testbench/pwm_decode_monitor.sv
/* Checker for phase 0 of the PWM input decoder.
 Assumes it is bound to the decoder top module. */
`timescale 1ns/1ps
module pwm_decode_monitor
  import pwm_decode_pkg::*;
#(parameter int PHASES = PHASE_COUNT) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic hw_config, // Source
  input wire logic [1:0] pwm_mode_field, // Mode
  input wire logic [1:0] mode_strap, // Strap
  input wire phase_in_s [PHASES-1:0] phase_in, // In
  input wire gate_pair_s [PHASES-1:0] gate_cmd, // Gates
  input wire switch_node_state_e [PHASES-1:0] switch_node_state, // Node
  input wire logic mode_unsupported // Bad mode
);
  // Mode sources and phase 0 shorthands
  wire f6 = !hw_config && pwm_mode_field == MODE_SIX_INPUT;
  wire f3 = !hw_config && pwm_mode_field == MODE_THREE_INPUT;
  wire s6 = hw_config && mode_strap == STRAP_GROUND;
  wire s3 = hw_config && mode_strap == STRAP_RES_47K;
  wire [1:0] p = phase_in[0];
  wire [1:0] g = gate_cmd[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_m6; (f6 && p == 2'h1)[*7] |-> switch_node_state[0] == NODE_LOW;
  endproperty
  a_m6: assert property (p_m6) else $error("six low");
  property p_t6; (f6 && p == 2'h3)[*7] |-> g == 2'h0; endproperty
  a_t6: assert property (p_t6) else $error("six both");
  property p_m3; (f3 && p == 2'h3)[*7] |-> g == 2'h2; endproperty
  a_m3: assert property (p_m3) else $error("three high");
  property p_z3; (f3 && !p[0])[*7] |-> g == 2'h0; endproperty
  a_z3: assert property (p_z3) else $error("three float");
  property p_l3; (f3 && p == 2'h1)[*7] |-> g == 2'h1; endproperty
  a_l3: assert property (p_l3) else $error("three low");
  property p_s3; (s3 && p == 2'h2)[*7] |-> g == 2'h0; endproperty
  a_s3: assert property (p_s3) else $error("strap three");
  property p_s6; (s6 && p == 2'h2)[*7] |-> g == 2'h2; endproperty
  a_s6: assert property (p_s6) else $error("strap six");
  property p_ex; g != 2'h3; endproperty
  a_ex: assert property (p_ex) else $error("both gates on");
  c_six: cover property (f6 && g == 2'h2);
  c_strap: cover property (s3 && g == 2'h1);
  c_three: cover property (f3 && g == 2'h1);
  c_bad: cover property (mode_unsupported);
endmodule : pwm_decode_monitor
bind halfbridge_pwm_input_decoder pwm_decode_monitor #(.PHASES(PHASES))
  u_pwm_decode_monitor
  (.sys_clk, .rst_n, .hw_config, .pwm_mode_field, .mode_strap, .phase_in,
  .gate_cmd, .switch_node_state, .mode_unsupported);

// File: testbench/motor_ctrl_model.sv
/* Controller model driving the decoder phase inputs.
 Assumes commands arrive just after a clock edge. */
`timescale 1ns/1ps
module motor_ctrl_model
  import pwm_decode_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic idle, // Park inputs low
  input wire logic tie_low, // Low inputs high
  input wire logic [5:0] cmd, // Levels
  output phase_in_s [2:0] phase_in // To decoder
);
  // Launch inputs just after each edge
  always @(posedge sys_clk) begin
    if (idle) phase_in <= #1 '0;
    else phase_in <= #1 cmd | (tie_low ? 6'h15 : 6'h00);
  end
endmodule : motor_ctrl_model

// File: testbench/halfbridge_pwm_input_decoder_bench.sv
/* Bench for the PWM input decoder: corner and random inputs per mode.
 Assumes the package, the checker and the controller model. */
`timescale 1ns/1ps
module halfbridge_pwm_input_decoder_bench
  import pwm_decode_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, hw_config = 0, idle = 1, tie_low = 0;
  logic [1:0] pwm_mode_field = 2'h0, mode_strap = 2'h0;
  logic [5:0] cmd = 6'h00;
  logic [31:0] seed = 32'hBA90, r;
  logic three, unsup;
  logic [4:0] e;
  phase_in_s [2:0] phase_in;
  gate_pair_s [2:0] gate_cmd;
  switch_node_state_e [2:0] switch_node_state;
  logic mode_unsupported;
  int errors = 0, compares = 0, cycles = 0;
  halfbridge_pwm_input_decoder u_halfbridge_pwm_input_decoder (.sys_clk,
    .rst_n, .hw_config, .pwm_mode_field, .mode_strap, .phase_in, .gate_cmd,
    .switch_node_state, .mode_unsupported);
  motor_ctrl_model u_motor_ctrl_model (.sys_clk, .idle, .tie_low, .cmd,
    .phase_in);
  // Clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      summarize();
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Gate pair and node state expected for one phase
  function logic [4:0] want(logic t, logic u, logic [1:0] p);
    if (u) return 5'h01;
    if (t) return !p[0] ? 5'h01 : p[1] ? 5'h14 : 5'h0A;
    return p == 2'h2 ? 5'h14 : p == 2'h1 ? 5'h0A : 5'h01;
  endfunction : want
  task chk(string n, logic [2:0] x, logic [2:0] g);
    compares++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // One compare task for each kind of result
  task chk_gate(logic [1:0] x, logic [1:0] g);
    chk("gate", {1'h0, x}, {1'h0, g});
  endtask : chk_gate
  task chk_node(logic [2:0] x, logic [2:0] g);
    chk("node", x, g);
  endtask : chk_node
  task chk_flag(logic x, logic g);
    chk("flag", {2'h0, x}, {2'h0, g});
  endtask : chk_flag
  task summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // Reset values, then field six, field three, strap six, strap three,
  // bad field code, bad strap code; the unused source holds the other mode
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    for (int k = 0; k < 3; k++) begin
      chk_gate({RESET_GATE, RESET_GATE}, gate_cmd[k]);
      chk_node(NODE_HIZ, switch_node_state[k]);
    end
    chk_flag(1'h0, mode_unsupported);
    rst_n = 1;
    for (int m = 0; m < 6; m++) begin
      idle = 1;
      repeat (8) @(posedge sys_clk);
      #1 hw_config = m[1] || m == 5;
      pwm_mode_field = m == 4 ? 2'h3 : {1'h0, m[0] ^ hw_config};
      mode_strap = m == 5 ? 2'h2 : {1'h0, m[0] ^ !hw_config};
      three = m[0] && m < 4;
      unsup = m > 3;
      repeat (8) @(posedge sys_clk);
      #1 idle = 0;
      for (int i = 0; i < 12; i++) begin
        r = xs();
        cmd = i < 4 ? {r[3:0], i[1:0]} : r[5:0];
        tie_low = three && i > 3 && i[0];
        repeat (9) @(posedge sys_clk);
        #1;
        for (int k = 0; k < 3; k++) begin
          e = want(three, unsup, cmd[2*k +: 2] | {1'b0, tie_low});
          chk_gate(e[4:3], gate_cmd[k]);
          chk_node(e[2:0], switch_node_state[k]);
        end
        chk_flag(unsup, mode_unsupported);
      end
    end
    summarize();
  end
endmodule : halfbridge_pwm_input_decoder_bench
